// ==== inc/sacc_pkg.sv ====
// shared constants, types and register map of the converter control block
// Behaviour
// - twelve-bit result, one decision per trial
// - up to one megasample per second throughput
// - differential or single-ended input, as selected
// - software starts single or continuous conversions
// - four hardware trigger sources start conversions
// - die temperature channel selectable like others
// - single-ended results are straight binary
// - differential results twos complement, shifted right
// - result in bits 27:16, sign above when differential
// - reset: acquisition eight, divider two, nineteen
// - start enable gates starts, not continuous
package sacc_pkg;
  localparam int unsigned SYS_CLK_HZ = 200_000_000;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned RES_W = 12;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CHAN_OFS = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] TIMING_OFS = 8'h10;
  localparam logic [15:0] CTRL_RST = 16'h0600;
  localparam logic [4:0] EXTRA_RST = 5'h13;
  localparam logic [4:0] CHAN_RST = 5'h00;
  localparam logic [4:0] TEMP_CHAN = 5'h10;
  localparam logic [2:0] DIV_MAX = 3'h5;
  localparam logic [3:0] TRIAL_FIRST = 4'hb;
  localparam logic [4:0] TRIAL_CLKS = 5'h0c;
  localparam logic [11:0] MID_CODE = 12'h800;
  localparam int unsigned RES_LSB = 16;
  localparam int unsigned SRC_N = 4;
  localparam int unsigned SRC_PIN = 0;
  localparam int unsigned SRC_LOGIC = 1;
  localparam int unsigned SRC_TMR0 = 2;
  localparam int unsigned SRC_TMR1 = 3;

  typedef enum logic [2:0] {
    CT_NONE = 3'b000,
    CT_PIN = 3'b001,
    CT_LOGIC = 3'b010,
    CT_TMR0 = 3'b011,
    CT_TMR1 = 3'b100,
    CT_SINGLE = 3'b101,
    CT_CONT = 3'b110,
    CT_RSV = 3'b111
  } sacc_ctype_t;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic temp_en;
    logic [2:0] clk_div;
    logic [1:0] acq_sel;
    logic start_en;
    logic rsv6;
    logic diff;
    logic [1:0] rsv_lo;
    sacc_ctype_t ctype;
  } sacc_ctrl_t;

  typedef struct packed {
    logic track;
    logic diff;
    logic [4:0] chan;
    logic [RES_W-1:0] dac_code;
  } sacc_afe_t;
endpackage

// ==== design/sacc_trig_sync.sv ====
// three-flop synchroniser with rising-edge pulse, one per trigger line
`timescale 1ns/1ps
module sacc_trig_sync #(
  parameter int unsigned W = 4
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic [W-1:0] level_in,
  output logic [W-1:0] rise_out
);
  logic [W-1:0] s1, s2, s3, stable;
  logic [W-1:0] next_stable, next_rise;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // a change counts only once the second and third stages agree
      assign next_stable[g] = (s2[g] == s3[g]) ? s3[g] : stable[g];
      assign next_rise[g] = next_stable[g] & ~stable[g];
    end
  endgenerate

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      stable <= '0;
      rise_out <= '0;
    end else begin
      s1 <= level_in;
      s2 <= s1;
      s3 <= s2;
      stable <= next_stable;
      rise_out <= next_rise;
    end
  end
endmodule // sacc_trig_sync

// ==== design/sacc_clk_div.sv ====
// converter clock enable: one pulse every 2**sel system clocks
`timescale 1ns/1ps
module sacc_clk_div (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic restart_in,
  input wire logic [2:0] sel_in,
  output logic tick_out
);
  import sacc_pkg::*;
  logic [4:0] cnt, next_cnt;
  logic [4:0] top;

  always_comb begin
    // codes above the largest divider fall back to it
    top = 5'((6'h01 << ((sel_in > DIV_MAX) ? DIV_MAX : sel_in)) - 6'h01);
    tick_out = (cnt == top);
    if (restart_in || tick_out) begin
      next_cnt = 5'h00;
    end else begin
      next_cnt = 5'(cnt + 5'h01);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cnt <= 5'h00;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule // sacc_clk_div

// ==== design/sacc_top.sv ====
// successive-approximation conversion control with apb register access
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module sacc_top (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [sacc_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic conversion_trigger_pin_in,
  input wire logic programmable_logic_array_in,
  input wire logic first_general_timer_ovf_in,
  input wire logic second_general_timer_ovf_in,
  input wire logic comparator_in,
  output sacc_pkg::sacc_afe_t afe_out,
  output logic busy_out,
  output logic result_ready_out
);
  import sacc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACQ = 3'b001,
    ST_TRIAL = 3'b010,
    ST_EXTRA = 3'b011,
    ST_DONE = 3'b100
  } sacc_state_t;

  function automatic logic map_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    map_hit = (a == ofs);
  endfunction

  // result word: 12 bits at 27:16, four sign copies above when differential, zeros when single-ended
  function automatic logic [31:0] encode(input logic [RES_W-1:0] code, input logic diff);
    logic [RES_W-1:0] tc;
    logic [RES_W-1:0] r;
    tc = code ^ MID_CODE;
    r = diff ? {tc[RES_W-1], tc[RES_W-1:1]} : code;
    encode = {{4{diff & r[RES_W-1]}}, r, 16'h0000};
  endfunction

  // ---------------- apb slave ----------------
  sacc_ctrl_t ctrl, next_ctrl;
  logic [4:0] chan, next_chan;
  logic [4:0] extra, next_extra;
  logic [31:0] result, next_result;
  logic ready, next_ready;
  logic [31:0] next_prdata;
  logic setup, access, wr, rd_result, wr_ctrl, mapped;

  always_comb begin
    setup = psel_in & ~penable_in;
    access = psel_in & penable_in;
    wr = access & pwrite_in;
    mapped = map_hit(paddr_in, CTRL_OFS) | map_hit(paddr_in, CHAN_OFS)
           | map_hit(paddr_in, RESULT_OFS) | map_hit(paddr_in, STATUS_OFS)
           | map_hit(paddr_in, TIMING_OFS);
    wr_ctrl = wr & map_hit(paddr_in, CTRL_OFS);
    rd_result = access & ~pwrite_in & map_hit(paddr_in, RESULT_OFS);
    pready_out = 1'b1;
    // unmapped addresses and writes to read-only words are flagged
    pslverr_out = access & (~mapped | (pwrite_in & (map_hit(paddr_in, RESULT_OFS)
                  | map_hit(paddr_in, STATUS_OFS))));
    next_ctrl = ctrl;
    next_chan = chan;
    next_extra = extra;
    if (wr_ctrl) begin
      next_ctrl = sacc_ctrl_t'(pwdata_in[15:0]);
      next_ctrl.rsv_hi = 2'h0;
      next_ctrl.rsv6 = 1'b0;
      next_ctrl.rsv_lo = 2'h0;
    end
    if (wr && map_hit(paddr_in, CHAN_OFS)) begin
      next_chan = pwdata_in[4:0];
    end
    if (wr && map_hit(paddr_in, TIMING_OFS)) begin
      next_extra = pwdata_in[4:0];
    end
    next_prdata = 32'h0000_0000;
    if (setup) begin
      case (paddr_in)
        CTRL_OFS: next_prdata = {16'h0000, ctrl};
        CHAN_OFS: next_prdata = {27'h0, chan};
        RESULT_OFS: next_prdata = result;
        STATUS_OFS: next_prdata = {30'h0, ready, busy_out};
        TIMING_OFS: next_prdata = {27'h0, extra};
        default: next_prdata = 32'h0000_0000;
      endcase
    end else if (access) begin
      next_prdata = prdata_out;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      ctrl <= sacc_ctrl_t'(CTRL_RST);
      chan <= CHAN_RST;
      extra <= EXTRA_RST;
      prdata_out <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      chan <= next_chan;
      extra <= next_extra;
      prdata_out <= next_prdata;
    end
  end

  // ---------------- triggers and clock enable ----------------
  logic [SRC_N-1:0] trig_lvl, trig_rise;
  logic tick, sw_single, sw_cont, hw_hit, start;
  logic [SRC_N-1:0] src_sel;

  assign trig_lvl = {second_general_timer_ovf_in, first_general_timer_ovf_in,
                     programmable_logic_array_in, conversion_trigger_pin_in};

  sacc_trig_sync #(.W(SRC_N)) u_sync (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .level_in(trig_lvl),
    .rise_out(trig_rise)
  );

  sacc_state_t state, next_state;
  logic [4:0] cnt, next_cnt;
  logic [3:0] bit_idx, next_bit_idx;
  logic [RES_W-1:0] sar, next_sar;
  logic cont_run, next_cont_run;

  // divider realigns at each start from idle so acquisition gets whole clocks; continuous repeats are not realigned
  sacc_clk_div u_div (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .restart_in(start),
    .sel_in(ctrl.clk_div),
    .tick_out(tick)
  );

  always_comb begin
    src_sel = '0;
    case (ctrl.ctype)
      CT_PIN: src_sel[SRC_PIN] = 1'b1;
      CT_LOGIC: src_sel[SRC_LOGIC] = 1'b1;
      CT_TMR0: src_sel[SRC_TMR0] = 1'b1;
      CT_TMR1: src_sel[SRC_TMR1] = 1'b1;
      default: src_sel = '0;
    endcase
    hw_hit = |(src_sel & trig_rise);
    // software starts act on the value being written
    sw_single = wr_ctrl & next_ctrl.start_en & (next_ctrl.ctype == CT_SINGLE);
    sw_cont = wr_ctrl & next_ctrl.start_en & (next_ctrl.ctype == CT_CONT);
    // edges seen while busy are dropped, not queued
    start = (state == ST_IDLE) & ((ctrl.start_en & hw_hit) | sw_single | sw_cont);
  end

  // ---------------- conversion sequencer ----------------
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bit_idx = bit_idx;
    next_sar = sar;
    next_cont_run = cont_run;
    next_result = result;
    next_ready = ready;
    // continuous series stops only when another type is written
    if (wr_ctrl && next_ctrl.ctype != CT_CONT) begin
      next_cont_run = 1'b0;
    end else if (sw_cont) begin
      next_cont_run = 1'b1;
    end
    if (rd_result) begin
      next_ready = 1'b0;
    end
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_ACQ;
          next_cnt = 5'(6'h02 << ctrl.acq_sel);
        end
      end
      ST_ACQ: begin
        if (tick) begin
          next_cnt = 5'(cnt - 5'h01);
          if (cnt == 5'h01) begin
            next_state = ST_TRIAL;
            next_bit_idx = TRIAL_FIRST;
            next_sar = MID_CODE;
          end
        end
      end
      ST_TRIAL: begin
        if (tick) begin
          // keep the trial bit when the input is above the dac level
          next_sar[bit_idx] = comparator_in;
          if (bit_idx != 4'h0) begin
            next_sar[bit_idx - 4'h1] = 1'b1;
            next_bit_idx = 4'(bit_idx - 4'h1);
          end else if (extra > TRIAL_CLKS) begin
            next_state = ST_EXTRA;
            next_cnt = 5'(extra - TRIAL_CLKS);
          end else begin
            next_state = ST_DONE;
          end
        end
      end
      ST_EXTRA: begin
        if (tick) begin
          next_cnt = 5'(cnt - 5'h01);
          if (cnt == 5'h01) begin
            next_state = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        next_result = encode(sar, ctrl.diff);
        next_ready = 1'b1;
        if (next_cont_run) begin
          next_state = ST_ACQ;
          next_cnt = 5'(6'h02 << ctrl.acq_sel);
        end else begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state <= ST_IDLE;
      cnt <= 5'h00;
      bit_idx <= 4'h0;
      sar <= 12'h000;
      cont_run <= 1'b0;
      result <= 32'h0000_0000;
      ready <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bit_idx <= next_bit_idx;
      sar <= next_sar;
      cont_run <= next_cont_run;
      result <= next_result;
      ready <= next_ready;
    end
  end

  always_comb begin
    busy_out = (state != ST_IDLE);
    result_ready_out = ready;
    afe_out.track = (state == ST_ACQ);
    afe_out.diff = ctrl.diff;
    afe_out.chan = ctrl.temp_en ? TEMP_CHAN : chan;
    afe_out.dac_code = sar;
  end
  // /1 divider, two acquisition clocks and twelve trials fit 1 MSPS at 41.78 MHz

  // ---------------- assertions ----------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  sequence s_last_trial;
    (state == ST_TRIAL) && tick && (bit_idx == 4'h0);
  endsequence

  a_trial_end: assert property (s_last_trial |=> (state == ST_EXTRA) || (state == ST_DONE))
    else $error("last bit trial did not end the trial phase");
  a_trial_step: assert property ((state == ST_TRIAL) && tick && (bit_idx != 4'h0)
      |=> (state == ST_TRIAL) && (bit_idx == $past(bit_idx) - 4'h1))
    else $error("bit index did not step down by one");
  a_gate_start: assert property ((state == ST_IDLE) && !ctrl.start_en && !wr_ctrl
      |=> state == ST_IDLE)
    else $error("conversion started with start enable clear");
  a_cont_repeat: assert property ((state == ST_DONE) && cont_run && !wr_ctrl
      |=> (state == ST_ACQ))
    else $error("continuous series did not restart");
  a_hw_start: assert property ((state == ST_IDLE) && ctrl.start_en && hw_hit
      |=> (state == ST_ACQ) ##1 (state != ST_IDLE))
    else $error("hardware trigger did not start a conversion");
  // a restart out of the trial or tail phases would show as a jump back to acquisition
  a_busy_ignore: assert property ((state == ST_TRIAL || state == ST_EXTRA) && hw_hit
      |=> state != ST_ACQ)
    else $error("trigger disturbed a running conversion");
  a_single_code: assert property ((state == ST_DONE) && !ctrl.diff
      |=> result == {4'h0, $past(sar), 16'h0000})
    else $error("single-ended result is not straight binary");
  a_diff_code: assert property ((state == ST_DONE) && ctrl.diff
      |=> $signed(result[31:16]) == (($signed({5'h00, $past(sar)}) - 17'sd2048) >>> 1))
    else $error("differential result coding wrong");
  // sign copies follow the mode at the time of the update, not a later mode change
  a_sign_fill: assert property ((state == ST_DONE)
      |=> result[31:28] == {4{result[27] & $past(ctrl.diff)}})
    else $error("upper result bits are not sign copies");
  a_temp_chan: assert property (ctrl.temp_en |-> afe_out.chan == TEMP_CHAN)
    else $error("temperature channel not selected");
  a_reset_vals: assert property ($past(srst_in) |-> (ctrl.acq_sel == 2'h2)
      && (ctrl.clk_div == 3'h1) && (extra == 5'd19))
    else $error("timing defaults wrong after reset");
endmodule // sacc_top

// ==== testbench/sacc_afe_model.sv ====
// behavioural analog front end: track-and-hold plus comparator against the trial word
`timescale 1ns/1ps
module sacc_afe_model (
  input wire logic ref_clk_in,
  input wire sacc_pkg::sacc_afe_t afe_in,
  input wire logic [11:0] level_in,
  output logic comparator_out
);
  import sacc_pkg::*;
  logic [11:0] held = 12'h000;
  // held only while tracking, so input moves during trials go unseen
  always @(posedge ref_clk_in) begin
    if (afe_in.track) held <= level_in;
  end
  // input sits half a code above level, so a trial equal to it is kept
  assign comparator_out = (held >= afe_in.dac_code);
endmodule // sacc_afe_model

// ==== testbench/testbench.sv ====
// self-checking bench for the conversion control block
`timescale 1ns/1ps
module testbench;
  import sacc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic cmp, pready, pslverr, busy, rdy;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] lfsr = 32'hda70;
  logic [3:0] trig = 4'h0;
  logic [11:0] level = 12'h000;
  logic [11:0] vals [4] = '{12'h000, 12'hfff, 12'h7ff, 12'h800};
  logic [15:0] c;
  sacc_afe_t afe;
  logic [32:0] notes [$];
  int errors = 0;
  int tests_run = 0;
  int n;

  initial forever #2.5 clk = ~clk;

  sacc_top sacc_top_i (.ref_clk_in(clk), .srst_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .conversion_trigger_pin_in(trig[SRC_PIN]), .programmable_logic_array_in(trig[SRC_LOGIC]),
    .first_general_timer_ovf_in(trig[SRC_TMR0]), .second_general_timer_ovf_in(trig[SRC_TMR1]),
    .comparator_in(cmp), .afe_out(afe), .busy_out(busy), .result_ready_out(rdy));
  sacc_afe_model sacc_afe_model_i (.ref_clk_in(clk), .afe_in(afe), .level_in(level),
    .comparator_out(cmp));

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
  endfunction

  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic hang();
    errors++;
    $display("[FAIL] wait expected done seen timeout");
    give_verdict();
  endtask

  // every transfer leaves a note: error flag and, for reads, the word
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] exp);
    int k;
    notes.push_back(exp);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) hang();
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1) begin
      if (notes.size() == 0) chk("apb note", 33'h0, 33'h1);
      else chk("apb", {pslverr, pwr ? 32'h0 : prdata}, notes.pop_front());
    end
  end

  task automatic wait_rdy();
    n = 0;
    while (rdy !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000) hang();
  endtask

  task automatic pulse(input int s);
    @(posedge clk);
    trig[s] <= 1'b1;
    repeat (8) @(posedge clk);
    trig[s] <= 1'b0;
    repeat (12) @(posedge clk);
  endtask

  // one conversion; src >= 0 fires that trigger twice, the second while busy
  task automatic conv(input logic [15:0] ctl, input logic [11:0] v, input logic [4:0] ch,
    input int src);
    logic [11:0] t;
    t = v ^ 12'h800;
    @(posedge clk);
    level <= v;
    apb(1'b1, CTRL_OFS, {16'h0, ctl}, 33'h0);
    repeat (2) @(negedge clk);
    chk("chan", afe.chan, ch);
    chk("diff", afe.diff, ctl[5]);
    if (src < 0) chk("track", afe.track, 1'b1);
    if (src >= 0) begin
      pulse(src);
      pulse(src);
    end
    wait_rdy();
    apb(1'b0, STATUS_OFS, 32'h0, 33'h2);
    apb(1'b0, RESULT_OFS, 32'h0, ctl[5] ? {1'b0, {5{t[11]}}, t[11:1], 16'h0}
      : {5'h0, v, 16'h0});
    apb(1'b0, STATUS_OFS, 32'h0, 33'h0);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, CTRL_OFS, 32'h0, 33'h0600);
    apb(1'b0, TIMING_OFS, 32'h0, 33'h13);
    apb(1'b0, STATUS_OFS, 32'h0, 33'h0);
    apb(1'b0, RESULT_OFS, 32'h0, 33'h0);
    apb(1'b0, 8'h14, 32'h0, 33'h100000000);
    apb(1'b1, RESULT_OFS, 32'h1, 33'h100000000);
    apb(1'b1, CTRL_OFS, 32'hffffebd8, 33'h0);
    apb(1'b0, CTRL_OFS, 32'h0, 33'h2b80);
    apb(1'b1, CHAN_OFS, 32'h3, 33'h0);
    apb(1'b0, CHAN_OFS, 32'h0, 33'h3);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      c = 16'h0085;
      c[11:10] = i[1:0];
      c[9:8] = i[2:1];
      c[5] = i[0];
      conv(c, (i >= 6) ? lfsr[11:0] : vals[i[2:1]], 5'h03, -1);
    end
    $display("test software single done");
    conv(16'h2685, lfsr[11:0], TEMP_CHAN, -1);
    for (int s = 0; s < 4; s++) begin
      lfsr = nxt(lfsr);
      conv(16'h0681 + 16'(s), lfsr[11:0], 5'h03, s);
    end
    $display("test hardware triggers done");
    apb(1'b1, CTRL_OFS, 32'h0601, 33'h0);
    pulse(SRC_PIN);
    apb(1'b0, STATUS_OFS, 32'h0, 33'h0);
    @(posedge clk);
    level <= lfsr[11:0];
    apb(1'b1, CTRL_OFS, 32'h0686, 33'h0);
    wait_rdy();
    apb(1'b0, RESULT_OFS, 32'h0, {5'h0, lfsr[11:0], 16'h0});
    apb(1'b1, CTRL_OFS, 32'h0606, 33'h0);
    wait_rdy();
    apb(1'b0, RESULT_OFS, 32'h0, {5'h0, lfsr[11:0], 16'h0});
    apb(1'b1, CTRL_OFS, 32'h0600, 33'h0);
    n = 0;
    while (busy !== 1'b0 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk("busy", busy, 33'h0);
    $display("test continuous done");
    give_verdict();
  end
endmodule // testbench
